//--- io_ports_cfg.svh
// Constants for the three shared I/O ports: register indices, reset values, bus codes.
// Assumes a 32-bit Avalon-MM register bus with byte addresses equal to four times the index.
`ifndef IO_PORTS_CFG_SVH
`define IO_PORTS_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_SEG_A_LATCH    6'h05
`define IDX_SEG_A_PIN      6'h0b
`define IDX_SEG_A_SELECT   6'h2a
`define IDX_ANA_DIRECTION  6'h30
`define IDX_ANA_LATCH      6'h31
`define IDX_ANA_PIN        6'h32
`define IDX_CONV_CONTROL   6'h33
`define IDX_SEG_B_LATCH    6'h34
`define IDX_SEG_B_PIN      6'h35
`define IDX_SEG_B_SELECT   6'h36

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CONV_DISABLE_BIT   0
`define RST_SEG_LATCH      8'hff
`define RST_SEG_SELECT     8'h00
`define RST_ANA_DIRECTION  8'h00
`define RST_ANA_LATCH      8'h00
`define RST_CONV_DISABLE   1'b1

// ----------------------------------------------------------------
// Bus widths, response codes and synchroniser depth
// ----------------------------------------------------------------
`define BUS_ADDR_W         8
`define RESP_OKAY          2'h0
`define RESP_DECODE_ERROR  2'h3
`define SYNC_STAGES        2

`endif

//--- io_ports_pkg.sv
// Types shared by the shared I/O port block.
// Assumes io_ports_cfg.svh supplies the numeric constants.
package io_ports_pkg;
  // One 8-bit port value
  typedef logic [7:0] port_byte_t;
  // Register bus handshake phase
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_phase_t;
endpackage

//--- io_pin_sync.sv
// Two-stage pin synchroniser for one 8-bit port.
// Assumes pins change asynchronously to clock_i; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module io_pin_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire io_ports_pkg::port_byte_t pin_i,
  output io_ports_pkg::port_byte_t sync_o
);
  import io_ports_pkg::*;

  port_byte_t first_stage; // Seen only by the second stage

  // ----------------------------------------------------------------
  // Two flip-flop stages
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_stage <= 8'h00;
      sync_o <= 8'h00;
    end else begin
      first_stage <= pin_i;
      sync_o <= first_stage;
    end
  end
endmodule
`default_nettype wire

//--- io_ports.sv
// Three 8-bit shared I/O ports: two LCD-segment-shared ports and one analog-shared port.
// Assumes an Avalon-MM master on clock_i, pins synchronous-free, LCD driver and converter outside.
// Functional notes
// - Port A latch resets to all ones
// - Port A select bit routes pin to LCD
// - Port A latch and pin read separately
// - Pin read under LCD select is undefined
// - Direction 1 drives analog port latch out
// - Analog port resets direction, latch, disable set
// - Disabled converter: latch 0 reads 0
// - Enabled converter: latch 0 is analog, reads 0
// - Port B eight bits, latch ones, select
// - Port B latch and pin read separately
`timescale 1ns/1ps
`include "io_ports_cfg.svh"
`default_nettype none
module io_ports (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Avalon-MM register slave
  input wire logic [`BUS_ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic [1:0] response_o,
  output logic waitrequest_o,
  // Segment-shared port A pins
  input wire io_ports_pkg::port_byte_t seg_a_pin_i,
  output io_ports_pkg::port_byte_t seg_a_pin_o,
  output io_ports_pkg::port_byte_t seg_a_pin_oe_o,
  input wire io_ports_pkg::port_byte_t seg_a_lcd_i,
  // Analog-shared port pins
  input wire io_ports_pkg::port_byte_t ana_pin_i,
  output io_ports_pkg::port_byte_t ana_pin_o,
  output io_ports_pkg::port_byte_t ana_pin_oe_o,
  output io_ports_pkg::port_byte_t ana_select_o,
  output io_ports_pkg::port_byte_t ana_function_o,
  // Segment-shared port B pins
  input wire io_ports_pkg::port_byte_t seg_b_pin_i,
  output io_ports_pkg::port_byte_t seg_b_pin_o,
  output io_ports_pkg::port_byte_t seg_b_pin_oe_o,
  input wire io_ports_pkg::port_byte_t seg_b_lcd_i
);
  import io_ports_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  port_byte_t seg_port_a_output_latch; // Port A latch
  port_byte_t seg_port_a_segment_select; // Port A LCD routing
  port_byte_t analog_port_direction; // 1 = output
  port_byte_t analog_port_output_latch; // Analog port latch
  logic converter_input_disable; // 1 = converter unused
  port_byte_t seg_port_b_output_latch; // Port B latch
  port_byte_t seg_port_b_segment_select; // Port B LCD routing
  port_byte_t seg_a_sync; // Synchronised port A pins
  port_byte_t ana_sync; // Synchronised analog port pins
  port_byte_t seg_b_sync; // Synchronised port B pins
  bus_phase_t phase; // Bus handshake phase

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two-stage pin sampling
  // Only the second stage of each leaves the synchroniser
  io_pin_sync sync_a (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(seg_a_pin_i), .sync_o(seg_a_sync));
  io_pin_sync sync_ana (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(ana_pin_i), .sync_o(ana_sync));
  io_pin_sync sync_b (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(seg_b_pin_i), .sync_o(seg_b_sync));

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [5:0] index = address_i[7:2]; // Word index
  wire request = read_i | write_i; // Any request
  wire commit = request & (phase == BUS_ANSWER); // Edge where request completes
  wire wr_en = commit & write_i & byteenable_i[0]; // Low byte write
  // One address hit per register
  wire hit_a_latch = (index == `IDX_SEG_A_LATCH);
  wire hit_a_pin = (index == `IDX_SEG_A_PIN);
  wire hit_a_sel = (index == `IDX_SEG_A_SELECT);
  wire hit_dir = (index == `IDX_ANA_DIRECTION);
  wire hit_ana_latch = (index == `IDX_ANA_LATCH);
  wire hit_ana_pin = (index == `IDX_ANA_PIN);
  wire hit_conv = (index == `IDX_CONV_CONTROL);
  wire hit_b_latch = (index == `IDX_SEG_B_LATCH);
  wire hit_b_pin = (index == `IDX_SEG_B_PIN);
  wire hit_b_sel = (index == `IDX_SEG_B_SELECT);
  wire mapped = hit_a_latch | hit_a_pin | hit_a_sel | hit_dir | hit_ana_latch | hit_ana_pin | hit_conv |
                hit_b_latch | hit_b_pin | hit_b_sel;

  // ----------------------------------------------------------------
  // Analog port input modes
  // ----------------------------------------------------------------
  // Input bits masked when latch 0, direction 0
  wire [7:0] ana_forced_zero = ~analog_port_direction & ~analog_port_output_latch;
  // Converter takes pins with latch 0, direction 0, disable clear
  wire [7:0] ana_analog_mode = ana_forced_zero & {8{~converter_input_disable}};
  wire [7:0] ana_read_value = ana_sync & ~ana_forced_zero; // Pin read with masking

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Separate latch and pin read paths
  // LCD-selected pin bits read raw, undefined
  // Unmapped indices read as zero
  wire [7:0] read_byte = hit_a_latch ? seg_port_a_output_latch :
                         hit_a_pin ? seg_a_sync :
                         hit_a_sel ? seg_port_a_segment_select :
                         hit_dir ? analog_port_direction :
                         hit_ana_latch ? analog_port_output_latch :
                         hit_ana_pin ? ana_read_value :
                         hit_conv ? {7'h00, converter_input_disable} :
                         hit_b_latch ? seg_port_b_output_latch :
                         hit_b_pin ? seg_b_sync :
                         hit_b_sel ? seg_port_b_segment_select : 8'h00;

  // Waitrequest high in the first cycle of each request
  assign waitrequest_o = request & (phase == BUS_IDLE);

  // ----------------------------------------------------------------
  // Bus phase
  // ----------------------------------------------------------------
  // One wait cycle per request, then the answer
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= BUS_IDLE;
    end else begin
      case (phase)
        BUS_IDLE: phase <= request ? BUS_ANSWER : BUS_IDLE; // Request seen
        BUS_ANSWER: phase <= BUS_IDLE; // Answer taken
        default: phase <= BUS_IDLE;
      endcase
    end
  end

  // Read data and response captured as the wait cycle ends
  // Writes and unmapped reads return zero data
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      readdata_o <= 32'h0000_0000;
      response_o <= `RESP_OKAY;
    end else if (request & (phase == BUS_IDLE)) begin
      readdata_o <= read_i ? {24'h00_0000, read_byte} : 32'h0000_0000;
      response_o <= mapped ? `RESP_OKAY : `RESP_DECODE_ERROR;
    end
  end

  // ----------------------------------------------------------------
  // Port A registers
  // ----------------------------------------------------------------
  // Latch ones, select zeros at reset
  // Writes land only at the commit edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_port_a_output_latch <= `RST_SEG_LATCH;
      seg_port_a_segment_select <= `RST_SEG_SELECT;
    end else begin
      if (wr_en & hit_a_latch) seg_port_a_output_latch <= writedata_i[7:0];
      if (wr_en & hit_a_sel) seg_port_a_segment_select <= writedata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Analog port registers
  // ----------------------------------------------------------------
  // Direction, latch cleared, disable set at reset
  // Writes land only at the commit edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_port_direction <= `RST_ANA_DIRECTION;
      analog_port_output_latch <= `RST_ANA_LATCH;
      converter_input_disable <= `RST_CONV_DISABLE;
    end else begin
      if (wr_en & hit_dir) analog_port_direction <= writedata_i[7:0];
      if (wr_en & hit_ana_latch) analog_port_output_latch <= writedata_i[7:0];
      if (wr_en & hit_conv) converter_input_disable <= writedata_i[`CONV_DISABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Port B registers
  // ----------------------------------------------------------------
  // Port B latch ones, select zeros
  // Writes land only at the commit edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_port_b_output_latch <= `RST_SEG_LATCH;
      seg_port_b_segment_select <= `RST_SEG_SELECT;
    end else begin
      if (wr_en & hit_b_latch) seg_port_b_output_latch <= writedata_i[7:0];
      if (wr_en & hit_b_sel) seg_port_b_segment_select <= writedata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // LCD routing per bit, else pull-low latch
  wire [7:0] seg_a_from_lcd = seg_a_lcd_i & seg_port_a_segment_select; // Panel bits
  wire [7:0] seg_a_from_latch = seg_port_a_output_latch & ~seg_port_a_segment_select; // Port bits
  assign seg_a_pin_o = seg_a_from_lcd | seg_a_from_latch;
  assign seg_a_pin_oe_o = seg_port_a_segment_select | ~seg_port_a_output_latch;
  wire [7:0] seg_b_from_lcd = seg_b_lcd_i & seg_port_b_segment_select; // Panel bits
  wire [7:0] seg_b_from_latch = seg_port_b_output_latch & ~seg_port_b_segment_select; // Port bits
  assign seg_b_pin_o = seg_b_from_lcd | seg_b_from_latch;
  assign seg_b_pin_oe_o = seg_port_b_segment_select | ~seg_port_b_output_latch;
  // Direction 1 drives the latch value
  assign ana_pin_o = analog_port_output_latch;
  assign ana_pin_oe_o = analog_port_direction;
  assign ana_select_o = ana_analog_mode;
  // Secondary functions see masked pin levels
  assign ana_function_o = ana_read_value;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic seen_edge; // Low only in the first cycle after reset
  // Marks the first edge after reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_edge <= 1'b0;
    end else begin
      seen_edge <= 1'b1;
    end
  end

  // All checks on the bus clock, off during reset
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  AST_A_LATCH_RESET: assert property (!seen_edge |-> seg_port_a_output_latch == 8'hff)
    else $error("Port A latch not all ones after reset");
  AST_A_LCD_ROUTE: assert property (((seg_a_pin_o ^ seg_a_lcd_i) & seg_port_a_segment_select) == 8'h00 &&
      (seg_port_a_segment_select & ~seg_a_pin_oe_o) == 8'h00)
    else $error("Port A segment bit not routed to LCD");
  AST_A_LATCH_READ: assert property (read_i && !waitrequest_o && hit_a_latch |->
      readdata_o[7:0] == seg_port_a_output_latch)
    else $error("Port A latch read mismatch");
  AST_A_PIN_READ: assert property (read_i && waitrequest_o && hit_a_pin |=>
      readdata_o[7:0] == $past(seg_a_sync))
    else $error("Port A pin read mismatch");
  AST_ANA_DRIVE: assert property (((ana_pin_o ^ analog_port_output_latch) & ana_pin_oe_o) == 8'h00 &&
      ana_pin_oe_o == analog_port_direction)
    else $error("Analog port output mode wrong");
  AST_ANA_RESET: assert property (!seen_edge |-> converter_input_disable && analog_port_direction == 8'h00 &&
      ana_function_o == 8'h00)
    else $error("Analog port reset state wrong");
  AST_ANA_ZERO: assert property (read_i && waitrequest_o && hit_ana_pin |=>
      (readdata_o[7:0] & $past(ana_forced_zero)) == 8'h00)
    else $error("Masked analog bit read nonzero");
  AST_ANA_CONVERT: assert property ((ana_select_o & (ana_function_o | ana_pin_oe_o)) == 8'h00)
    else $error("Analog input bit not zero or driven");
  AST_B_RESET: assert property (!seen_edge |-> seg_port_b_output_latch == 8'hff &&
      seg_port_b_segment_select == 8'h00)
    else $error("Port B reset state wrong");
  AST_B_PIN_READ: assert property (read_i && waitrequest_o && hit_b_pin |=>
      readdata_o[7:0] == $past(seg_b_sync))
    else $error("Port B pin read mismatch");
  AST_B_LATCH_READ: assert property (read_i && !waitrequest_o && hit_b_latch |->
      readdata_o[7:0] == seg_port_b_output_latch)
    else $error("Port B latch read mismatch");
  AST_B_LCD_ROUTE: assert property (((seg_b_pin_o ^ seg_b_lcd_i) & seg_port_b_segment_select) == 8'h00 &&
      (seg_port_b_segment_select & ~seg_b_pin_oe_o) == 8'h00)
    else $error("Port B segment bit not routed to LCD");
  AST_SYNC_DELAY: assert property (seen_edge && $past(seen_edge) |=> seg_a_sync == $past(seg_a_pin_i, 2))
    else $error("Port A synchroniser delay wrong");
  AST_BUS_WAIT: assert property ($rose(request) |-> waitrequest_o ##1 !waitrequest_o)
    else $error("Bus answer not after one wait cycle");
  AST_A_LATCH_WRITE: assert property (write_i && !waitrequest_o && byteenable_i[0] && hit_a_latch |=>
      seg_port_a_output_latch == $past(writedata_i[7:0]))
    else $error("Port A latch write lost");
  AST_A_SELECT_WRITE: assert property (write_i && !waitrequest_o && byteenable_i[0] && hit_a_sel |=>
      seg_port_a_segment_select == $past(writedata_i[7:0]))
    else $error("Port A select write lost");
  AST_CONV_WRITE: assert property (write_i && !waitrequest_o && byteenable_i[0] && hit_conv |=>
      converter_input_disable == $past(writedata_i[`CONV_DISABLE_BIT]))
    else $error("Converter control write lost");
  AST_LANE_OFF: assert property (write_i && !waitrequest_o && !byteenable_i[0] |=>
      $stable(seg_port_a_output_latch) && $stable(seg_port_b_output_latch) && $stable(analog_port_output_latch))
    else $error("Write with low lane off changed a latch");
  AST_DECODE_ERROR: assert property (request && waitrequest_o && !mapped |=>
      response_o == `RESP_DECODE_ERROR)
    else $error("Unmapped access not answered with decode error");

  CVR_A_LCD: cover property (wr_en && hit_a_sel && writedata_i[7:0] != 8'h00);
  CVR_ANA_CONVERT: cover property (ana_select_o != 8'h00);
  CVR_B_PIN_READ: cover property (commit && read_i && hit_b_pin);
  CVR_UNMAPPED: cover property (commit && !mapped);
  CVR_ANA_OUTPUT: cover property (ana_pin_oe_o != 8'h00);
endmodule
`default_nettype wire

//--- pin_world.sv
// Behavioural model of what hangs on one 8-bit port: pads and outside sources.
// Assumes the bench sets the level that outside circuits impose on released pins.
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] level_o
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // Driven bits show the block's value, released bits the outside level
  assign level_o = (oe_i & pin_o_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

//--- lcd_analog_shared_io_ports_tb.sv
// Self-checking bench for the shared I/O port block over its register bus.
// Assumes io_ports, pin_world and the register index constants of io_ports_cfg.svh.
`timescale 1ns/1ps
`include "io_ports_cfg.svh"
`default_nettype none
module lcd_analog_shared_io_ports_tb;
  import io_ports_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] ben = 4'h1;
  wire logic [31:0] rdata;
  wire logic [1:0] resp;
  wire logic wreq;
  port_byte_t ext [2] = '{8'hc3, 8'hc3};  // Outside level, ports A and B
  port_byte_t lcd [2] = '{8'ha5, 8'ha5};  // Segment driver values
  port_byte_t n_ext = 8'hff;  // Analog port outside level
  port_byte_t lvl [2];
  port_byte_t o [2];
  port_byte_t oe [2];
  port_byte_t n_lvl, n_o, n_oe, n_sel, n_fun;
  logic [31:0] rd;  // Last read data
  logic [1:0] rsp;  // Last response
  int num_errors = 0;
  int total_checks = 0;
  // Free-running 200 MHz clock
  always #2.5 clock_i = ~clock_i;
  // ----------------------------------------------------------------
  // Block and pin models
  // ----------------------------------------------------------------
  io_ports u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .address_i(address), .read_i(read),
    .write_i(write), .writedata_i(wdata), .byteenable_i(ben), .readdata_o(rdata),
    .response_o(resp), .waitrequest_o(wreq), .seg_a_pin_i(lvl[0]), .seg_a_pin_o(o[0]),
    .seg_a_pin_oe_o(oe[0]), .seg_a_lcd_i(lcd[0]), .ana_pin_i(n_lvl), .ana_pin_o(n_o),
    .ana_pin_oe_o(n_oe), .ana_select_o(n_sel), .ana_function_o(n_fun), .seg_b_pin_i(lvl[1]),
    .seg_b_pin_o(o[1]), .seg_b_pin_oe_o(oe[1]), .seg_b_lcd_i(lcd[1]));
  pin_world u_pads_a (.pin_o_i(o[0]), .oe_i(oe[0]), .ext_i(ext[0]), .level_o(lvl[0]));
  pin_world u_pads_b (.pin_o_i(o[1]), .oe_i(oe[1]), .ext_i(ext[1]), .level_o(lvl[1]));
  pin_world u_pads_n (.pin_o_i(n_o), .oe_i(n_oe), .ext_i(n_ext), .level_o(n_lvl));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One bus transfer; request stays up so calls may run back to back
  task automatic bus(input bit is_rd, input logic [5:0] idx, input logic [7:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    read <= is_rd;
    write <= !is_rd;
    address <= {idx, 2'b00};
    wdata <= {24'h0, wd};
    ben <= be;
    do begin
      @(posedge clock_i);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    if (wreq !== 1'b0) begin
      num_errors++;  // Bus never answered
      end_sim();
    end else begin
      rd = rdata;
      rsp = resp;
    end
  endtask
  // Full-byte write, low lane
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b0, idx, d, 4'h1);
  endtask
  // Read and compare data plus an OKAY response
  task automatic rdc(input string name, input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00, 4'h1);
    chk(name, {rsp, rd}, {2'h0, 24'h0, exp});
  endtask
  // Drop the request for one cycle
  task automatic idle;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock_i);
  endtask
  // Reset values of every register except the port A and port B pin reads
  task automatic check_reset;
    rdc("a_latch", `IDX_SEG_A_LATCH, 8'hff);
    rdc("a_select", `IDX_SEG_A_SELECT, 8'h00);
    rdc("n_dir", `IDX_ANA_DIRECTION, 8'h00);
    rdc("n_latch", `IDX_ANA_LATCH, 8'h00);
    rdc("conv_ctl", `IDX_CONV_CONTROL, 8'h01);
    rdc("n_pin", `IDX_ANA_PIN, 8'h00);
    rdc("b_latch", `IDX_SEG_B_LATCH, 8'hff);
    rdc("b_select", `IDX_SEG_B_SELECT, 8'h00);
    chk("n_oe", n_oe, 8'h00);
  endtask
  // Latch, pin read and segment routing of one segment-shared port
  task automatic seg_port(input int p, input logic [5:0] li, input logic [5:0] pi, input logic [5:0] si);
    wr(li, 8'hff);
    wr(li, 8'h5a);
    bus(1'b0, li, 8'h00, 4'h0);  // Lane disabled, must not land
    rdc("seg_latch", li, 8'h5a);
    idle;
    repeat (3) @(posedge clock_i);
    rdc("seg_pin", pi, 8'h42);
    wr(si, 8'hf0);  // upper half to panel
    idle;
    chk("seg_route", {oe[p], o[p]}, {8'hf5, 8'haa});
    repeat (3) @(posedge clock_i);
    bus(1'b1, pi, 8'h00, 4'h1);
    chk("seg_pin_low", rd[3:0], 4'h2);  // selected bits not compared
    wr(si, 8'h00);  // back to port use
    idle;
    chk("seg_port", {oe[p], o[p]}, {8'ha5, 8'h5a});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    n_ext <= 8'hff;
    check_reset;
    seg_port(0, `IDX_SEG_A_LATCH, `IDX_SEG_A_PIN, `IDX_SEG_A_SELECT);
    seg_port(1, `IDX_SEG_B_LATCH, `IDX_SEG_B_PIN, `IDX_SEG_B_SELECT);
    // Unmapped index answers with a decode error and zero data
    bus(1'b1, 6'h3f, 8'h00, 4'h1);
    chk("unmapped", {rsp, rd}, {2'h3, 32'h0});
    n_ext <= 8'h96;
    // inputs need latch 1, direction 0
    wr(`IDX_ANA_DIRECTION, 8'h00);
    wr(`IDX_ANA_LATCH, 8'hff);  // whole-byte writes only
    idle;
    repeat (3) @(posedge clock_i);
    rdc("n_pin_in", `IDX_ANA_PIN, 8'h96);
    // analog candidates get latch 0, direction 0
    wr(`IDX_ANA_LATCH, 8'h0f);
    idle;
    repeat (3) @(posedge clock_i);
    rdc("n_pin_fixed", `IDX_ANA_PIN, 8'h06);
    chk("n_sel_off", n_sel, 8'h00);
    wr(`IDX_CONV_CONTROL, 8'h00);
    idle;
    chk("n_sel_on", n_sel, 8'hf0);
    rdc("n_pin_ana", `IDX_ANA_PIN, 8'h06);
    chk("n_fun", n_fun, 8'h06);
    // converter idle again before any output write
    wr(`IDX_CONV_CONTROL, 8'h01);
    wr(`IDX_ANA_DIRECTION, 8'h81);
    idle;
    chk("n_drive", {n_oe, n_o}, {8'h81, 8'h0f});
    repeat (3) @(posedge clock_i);
    rdc("n_pin_out", `IDX_ANA_PIN, 8'h07);
    idle;
    n_ext <= 8'h69;
    @(posedge clock_i);
    rdc("n_pin_old", `IDX_ANA_PIN, 8'h07);
    rdc("n_pin_new", `IDX_ANA_PIN, 8'h09);
    // Second reset in mid-run
    idle;
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    check_reset;
    end_sim();
  end
endmodule
`default_nettype wire
